//--- pkg/lcc_pkg.sv
// Constants, field layouts and types for the LCD control and contrast mode block
package lcc_pkg;

	// Register addresses on the special function register port
	localparam logic [7:0] ADDR_CONTRAST   = 8'h9C;
	localparam logic [7:0] ADDR_SEG_CTL    = 8'h9D;
	localparam logic [7:0] ADDR_MASTER_CTL = 8'hAB;
	localparam logic [7:0] ADDR_MASTER_CFG = 8'hAC;
	localparam logic [7:0] ADDR_POWER_CTL  = 8'hAD;
	localparam logic [7:0] ADDR_SUPPLY_MON = 8'hAE;
	localparam logic [7:0] ADDR_STATUS     = 8'hAF;

	// Values after reset
	localparam logic [7:0] RST_SEG_CTL    = 8'h00;
	localparam logic [7:0] RST_CONTRAST   = 8'h00;
	localparam logic [7:0] RST_MASTER_CTL = 8'h20;
	localparam logic [7:0] RST_MASTER_CFG = 8'h00;
	localparam logic [7:0] RST_POWER_CTL  = 8'h00;
	localparam logic [7:0] RST_SUPPLY_MON = 8'h00;

	// Field positions and masks
	localparam int         REDUCED_DRIVE_BIT = 2;
	localparam int         BYPASS_CFG_BIT    = 0;
	localparam int         PUMP_EN_BIT       = 3;
	localparam int         MONITOR_EN_BIT    = 7;
	localparam logic [7:0] SEG_CTL_WMASK     = 8'h7F;
	localparam logic [7:0] MASTER_CTL_WMASK  = 8'h7F;
	localparam logic [7:0] CONTRAST_WMASK    = 8'h1F;

	// Segment geometry
	localparam int PIN_COUNT      = 32;
	localparam int PIN_COUNT_HALF = 16;
	localparam int COM_COUNT      = 4;
	localparam int SEG_BITS       = 128;

	// Prescale codes
	localparam logic [1:0] DIV_BY_1 = 2'h0;
	localparam logic [1:0] DIV_BY_2 = 2'h1;
	localparam logic [1:0] DIV_BY_4 = 2'h2;
	localparam logic [1:0] PRESC_LAST = 2'h3;

	// Contrast setpoint scale in millivolts
	localparam logic [11:0] SETPOINT_BASE_MV = 12'h76C;
	localparam logic [6:0]  SETPOINT_STEP_MV = 7'h3C;

	typedef enum logic [1:0]
	{
		MUX_STATIC = 2'b00,
		MUX_TWO    = 2'b01,
		MUX_THREE  = 2'b10,
		MUX_FOUR   = 2'b11
	} lcc_mux_t;

	typedef enum logic [2:0]
	{
		MODE_NONE     = 3'b000,
		MODE_BYPASS   = 3'b001,
		MODE_MINIMUM  = 3'b010,
		MODE_CONSTANT = 3'b011,
		MODE_AUTO     = 3'b100
	} lcc_mode_t;

	typedef struct packed
	{
		logic       reserved;
		logic [1:0] refresh_clock_prescale;
		logic       blank;
		logic       size;
		lcc_mux_t   backplane_count_sel;
		logic       bias;
	} lcc_seg_ctl_t;

	typedef struct packed
	{
		logic bypass;
		logic resistor;
		logic pump;
	} lcc_rail_t;

endpackage

//--- verilog/lcc_sync.sv
// Two flip-flop synchroniser for a level input
`timescale 1ns/10ps
module lcc_sync
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic nrst,
	// Level in and out
	input  wire logic level_in,
	output logic      level_out
);

	logic stage1_reg;

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			stage1_reg <= 1'b0;
			level_out  <= 1'b0;
		end
		else
		begin
			stage1_reg <= level_in;
			level_out  <= stage1_reg;
		end
	end

endmodule

//--- verilog/lcc_top.sv
// LCD segment driver control register and contrast mode selection
`timescale 1ns/10ps
// Operation
// RULE_01 - Control top bit reads zero, writes zero
// RULE_02 - Prescale divides oscillator by one, two, four
// RULE_03 - Blank turns all segments off
// RULE_04 - Size selects sixteen or thirty-two segment pins
// RULE_05 - Backplane field selects static to four-mux
// RULE_06 - Bias bit selects third or half bias
// RULE_07 - Bias ignored in static drive
// RULE_08 - Setpoint steps sixty millivolts from 1.9 V
// RULE_09 - Mode one bypasses, rail follows battery
// RULE_10 - Software pattern selects minimum contrast mode
// RULE_11 - Minimum mode: battery, pump when battery low
// RULE_12 - Software pattern selects constant contrast mode
// RULE_13 - Constant mode: resistor, pump when battery low
// RULE_14 - Software pattern selects auto-bypass mode
// RULE_15 - Auto mode: resistor, bypass when low, no pump
// RULE_16 - Reduced drive may be cleared in modes three, four
// RULE_17 - Setpoint is five-bit code, low to high
// RULE_18 - Master control bit two is reduced drive
// RULE_19 - Battery monitor result synchronised before use
module lcc_top
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 nrst,
	// Register port
	input  wire logic [7:0]           sfr_addr,
	input  wire logic [7:0]           sfr_wdata,
	input  wire logic                 sfr_wr,
	input  wire logic                 sfr_rd,
	output logic [7:0]                sfr_rdata,
	// Oscillator tick and refresh clock enable
	input  wire logic                 rtc_tick,
	output logic                      refresh_tick,
	// Segment pattern and drive
	input  wire logic [127:0]         segment_pattern_regs,
	output logic [127:0]              seg_drive,
	output logic                      seg_pins_wide,
	output lcc_pkg::lcc_mux_t         backplane_mode,
	output logic                      half_bias,
	// Contrast and supply path
	input  wire logic                 battery_low,
	output logic [4:0]                contrast_code,
	output logic [11:0]               setpoint_mv,
	output lcc_pkg::lcc_mode_t        contrast_mode,
	output lcc_pkg::lcc_rail_t        rail_sel,
	output logic                      reduced_drive_sel,
	output logic                      mode_invalid
);

	lcc_pkg::lcc_seg_ctl_t segment_driver_control;
	logic [7:0]            contrast_setpoint_reg;
	logic [7:0]            master_ctl_reg;
	logic [7:0]            master_cfg_reg;
	logic [7:0]            power_ctl_reg;
	logic [7:0]            supply_monitor_ctl_reg;
	logic [1:0]            presc_cnt_reg;
	logic                  bat_low_sync;
	lcc_pkg::lcc_mode_t    mode_next;
	lcc_pkg::lcc_rail_t    rail_next;
	logic [127:0]          seg_next;
	logic [7:0]            rdata_next;
	logic                  presc_hit;

	lcc_sync u_bat_sync
	(
		.clock     (clock),
		.nrst      (nrst),
		.level_in  (battery_low),
		.level_out (bat_low_sync)
	); // see RULE_19

	// Register writes
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			segment_driver_control <= lcc_pkg::RST_SEG_CTL;
			contrast_setpoint_reg  <= lcc_pkg::RST_CONTRAST;
			master_ctl_reg         <= lcc_pkg::RST_MASTER_CTL;
			master_cfg_reg         <= lcc_pkg::RST_MASTER_CFG;
			power_ctl_reg          <= lcc_pkg::RST_POWER_CTL;
			supply_monitor_ctl_reg <= lcc_pkg::RST_SUPPLY_MON;
		end
		else if (sfr_wr)
		begin
			case (sfr_addr)
				lcc_pkg::ADDR_SEG_CTL:
					segment_driver_control <= sfr_wdata & lcc_pkg::SEG_CTL_WMASK; // see RULE_01
				lcc_pkg::ADDR_CONTRAST:
					contrast_setpoint_reg <= sfr_wdata & lcc_pkg::CONTRAST_WMASK; // see RULE_17
				lcc_pkg::ADDR_MASTER_CTL:
					master_ctl_reg <= sfr_wdata & lcc_pkg::MASTER_CTL_WMASK;
				lcc_pkg::ADDR_MASTER_CFG:
					master_cfg_reg <= sfr_wdata;
				lcc_pkg::ADDR_POWER_CTL:
					power_ctl_reg <= sfr_wdata;
				lcc_pkg::ADDR_SUPPLY_MON:
					supply_monitor_ctl_reg <= sfr_wdata;
				default:
					begin
					end
			endcase
		end
	end

	// Read data mux, unmapped addresses read zero
	always_comb
	begin
		case (sfr_addr)
			lcc_pkg::ADDR_SEG_CTL:    rdata_next = segment_driver_control; // see RULE_01
			lcc_pkg::ADDR_CONTRAST:   rdata_next = contrast_setpoint_reg;
			lcc_pkg::ADDR_MASTER_CTL: rdata_next = master_ctl_reg;
			lcc_pkg::ADDR_MASTER_CFG: rdata_next = master_cfg_reg;
			lcc_pkg::ADDR_POWER_CTL:  rdata_next = power_ctl_reg;
			lcc_pkg::ADDR_SUPPLY_MON: rdata_next = supply_monitor_ctl_reg;
			lcc_pkg::ADDR_STATUS:     rdata_next = {1'b0, bat_low_sync, rail_sel, contrast_mode};
			default:                  rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			sfr_rdata <= 8'h00;
		else if (sfr_rd)
			sfr_rdata <= rdata_next;
	end

	// Refresh clock prescaler on the oscillator tick
	always_comb
	begin
		case (segment_driver_control.refresh_clock_prescale)
			lcc_pkg::DIV_BY_1: presc_hit = 1'b1; // see RULE_02
			lcc_pkg::DIV_BY_2: presc_hit = presc_cnt_reg[0];
			default:           presc_hit = (presc_cnt_reg == lcc_pkg::PRESC_LAST);
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			presc_cnt_reg <= 2'h0;
			refresh_tick  <= 1'b0;
		end
		else
		begin
			if (rtc_tick)
				presc_cnt_reg <= presc_cnt_reg + 2'h1;
			refresh_tick <= rtc_tick & presc_hit; // see RULE_02
		end
	end

	// Segment gating by blank, pin count and backplane count
	always_comb
	begin
		logic [3:0] com_mask;
		com_mask = 4'h0;
		case (segment_driver_control.backplane_count_sel)
			lcc_pkg::MUX_STATIC: com_mask = 4'h1; // see RULE_05
			lcc_pkg::MUX_TWO:    com_mask = 4'h3;
			lcc_pkg::MUX_THREE:  com_mask = 4'h7;
			lcc_pkg::MUX_FOUR:   com_mask = 4'hF;
			default:             com_mask = 4'h0;
		endcase
		seg_next = '0;
		for (int i = 0; i < lcc_pkg::PIN_COUNT; i++)
		begin
			if (!segment_driver_control.blank &&
			    (segment_driver_control.size || i < lcc_pkg::PIN_COUNT_HALF)) // see RULE_03 RULE_04
				seg_next[i*lcc_pkg::COM_COUNT +: lcc_pkg::COM_COUNT] =
					segment_pattern_regs[i*lcc_pkg::COM_COUNT +: lcc_pkg::COM_COUNT] & com_mask;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			seg_drive      <= '0;
			seg_pins_wide  <= 1'b0;
			backplane_mode <= lcc_pkg::MUX_STATIC;
			half_bias      <= 1'b0;
		end
		else
		begin
			seg_drive      <= seg_next;
			seg_pins_wide  <= segment_driver_control.size; // see RULE_04
			backplane_mode <= segment_driver_control.backplane_count_sel; // see RULE_05
			half_bias      <= segment_driver_control.bias && // see RULE_06 RULE_07
			                  segment_driver_control.backplane_count_sel != lcc_pkg::MUX_STATIC;
		end
	end

	// Contrast mode decode from the four selection bits
	always_comb
	begin
		logic rd;
		logic byp;
		logic pmp;
		logic mon;
		rd  = master_ctl_reg[lcc_pkg::REDUCED_DRIVE_BIT]; // see RULE_18
		byp = master_cfg_reg[lcc_pkg::BYPASS_CFG_BIT];
		pmp = power_ctl_reg[lcc_pkg::PUMP_EN_BIT];
		mon = supply_monitor_ctl_reg[lcc_pkg::MONITOR_EN_BIT];
		mode_next = lcc_pkg::MODE_NONE;
		if (!rd && byp && !pmp && !mon)
			mode_next = lcc_pkg::MODE_BYPASS; // see RULE_09
		else if (!rd && byp && pmp && mon)
			mode_next = lcc_pkg::MODE_MINIMUM; // see RULE_10
		else if (!byp && pmp && mon)
			mode_next = lcc_pkg::MODE_CONSTANT; // see RULE_12 RULE_16
		else if (!byp && !pmp && mon)
			mode_next = lcc_pkg::MODE_AUTO; // see RULE_14 RULE_16
		rail_next = '0;
		case (mode_next)
			lcc_pkg::MODE_BYPASS:   rail_next.bypass = 1'b1; // see RULE_09
			lcc_pkg::MODE_MINIMUM:
				begin
					rail_next.bypass = !bat_low_sync; // see RULE_11
					rail_next.pump   = bat_low_sync;
				end
			lcc_pkg::MODE_CONSTANT:
				begin
					rail_next.resistor = !bat_low_sync; // see RULE_13
					rail_next.pump     = bat_low_sync;
				end
			lcc_pkg::MODE_AUTO:
				begin
					rail_next.resistor = !bat_low_sync; // see RULE_15
					rail_next.bypass   = bat_low_sync;
				end
			default: rail_next = '0;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			contrast_mode     <= lcc_pkg::MODE_NONE;
			rail_sel          <= '0;
			reduced_drive_sel <= 1'b0;
			mode_invalid      <= 1'b0;
			contrast_code     <= 5'h00;
			setpoint_mv       <= lcc_pkg::SETPOINT_BASE_MV;
		end
		else
		begin
			contrast_mode     <= mode_next;
			rail_sel          <= rail_next;
			reduced_drive_sel <= master_ctl_reg[lcc_pkg::REDUCED_DRIVE_BIT]; // see RULE_18
			mode_invalid      <= (mode_next == lcc_pkg::MODE_NONE);
			contrast_code     <= contrast_setpoint_reg[4:0]; // see RULE_17
			setpoint_mv       <= lcc_pkg::SETPOINT_BASE_MV +
			                     12'(contrast_setpoint_reg[4:0] * lcc_pkg::SETPOINT_STEP_MV); // see RULE_08
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	// Outputs are registered, so most checks look one cycle after the cause
	reserved_read_a: assert property (sfr_rd // see RULE_01
		&& sfr_addr == lcc_pkg::ADDR_SEG_CTL |=> !sfr_rdata[7])
		else $error("control top bit read nonzero");
	prescale_div1_a: assert property (rtc_tick // see RULE_02
		&& segment_driver_control.refresh_clock_prescale == lcc_pkg::DIV_BY_1
		|=> refresh_tick)
		else $error("divide by one missed a tick");
	refresh_gate_a: assert property (!rtc_tick |=> !refresh_tick) // see RULE_02
		else $error("refresh tick without oscillator tick");
	blank_off_a: assert property (segment_driver_control.blank // see RULE_03
		|=> seg_drive == '0)
		else $error("segment on while blanked");
	size_pins_a: assert property (!segment_driver_control.size // see RULE_04
		|=> seg_drive[127:64] == '0)
		else $error("upper pins driven in narrow size");
	static_bias_a: assert property ( // see RULE_07
		segment_driver_control.backplane_count_sel == lcc_pkg::MUX_STATIC
		|=> !half_bias && seg_drive[3:1] == 3'h0)
		else $error("bias or extra commons used in static mode");
	bypass_mode_a: assert property (mode_next == lcc_pkg::MODE_BYPASS // see RULE_09
		|=> rail_sel == 3'b100 && contrast_mode == lcc_pkg::MODE_BYPASS)
		else $error("bypass mode rail wrong");
	min_low_pump_a: assert property (mode_next == lcc_pkg::MODE_MINIMUM // see RULE_11
		&& bat_low_sync |=> rail_sel.pump && !rail_sel.bypass)
		else $error("minimum mode pump not on when low");
	const_high_res_a: assert property (mode_next == lcc_pkg::MODE_CONSTANT // see RULE_13
		&& !bat_low_sync |=> rail_sel == 3'b010)
		else $error("constant mode not on resistor");
	auto_no_pump_a: assert property (contrast_mode == lcc_pkg::MODE_AUTO // see RULE_15
		|-> !rail_sel.pump && $onehot(rail_sel))
		else $error("auto bypass mode rail wrong");
	rail_onehot_a: assert property (contrast_mode != lcc_pkg::MODE_NONE // see RULE_11 RULE_13
		|-> $onehot(rail_sel))
		else $error("valid mode without exactly one rail source");
	contrast_write_a: assert property (sfr_wr // see RULE_17
		&& sfr_addr == lcc_pkg::ADDR_CONTRAST
		|=> ##1 contrast_code == $past(sfr_wdata[4:0], 2))
		else $error("contrast code not updated");
	sync_delay_a: assert property (battery_low [*3] |=> bat_low_sync) // see RULE_19
		else $error("battery low not synchronised in time");

	cover_min_pump_c: cover property (contrast_mode == lcc_pkg::MODE_MINIMUM
		&& rail_sel.pump);
	cover_auto_bypass_c: cover property (contrast_mode == lcc_pkg::MODE_AUTO
		&& rail_sel.bypass);
	cover_const_res_c: cover property (contrast_mode == lcc_pkg::MODE_CONSTANT
		&& rail_sel.resistor);
	cover_bypass_rail_c: cover property (contrast_mode == lcc_pkg::MODE_BYPASS
		&& rail_sel.bypass);
	cover_div4_c: cover property (refresh_tick
		&& segment_driver_control.refresh_clock_prescale == lcc_pkg::DIV_BY_4);

endmodule

//--- bench/lcc_panel.sv
// Behavioural glass panel that counts refresh frames and lit segments
`timescale 1ns/10ps
module lcc_panel
(
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         nrst,
	// Panel drive
	input  wire logic         refresh_tick,
	input  wire logic [127:0] seg_drive,
	// Observed panel state
	output logic [15:0]       frame_count,
	output logic [7:0]        lit_count
);
	always_ff @(posedge clock)
	begin
		if (!nrst)
			frame_count <= 16'h0000;
		else if (refresh_tick)
			frame_count <= frame_count + 16'h0001;
	end
	// Segments the glass shows lit at this moment
	always_comb
	begin
		lit_count = 8'($countones(seg_drive));
	end
endmodule

//--- bench/lcc_top_tb.sv
// Register level testbench for the LCD control and contrast mode block
`timescale 1ns/10ps
module lcc_top_tb;
	logic                     clock;
	logic                     nrst;
	logic [7:0]               sfr_addr;
	logic [7:0]               sfr_wdata;
	logic                     sfr_wr;
	logic                     sfr_rd;
	logic [7:0]               sfr_rdata;
	logic                     rtc_tick;
	logic                     refresh_tick;
	logic [127:0]             segment_pattern_regs;
	logic [127:0]             seg_drive;
	logic                     seg_pins_wide;
	lcc_pkg::lcc_mux_t        backplane_mode;
	logic                     half_bias;
	logic                     battery_low;
	logic [4:0]               contrast_code;
	logic [11:0]              setpoint_mv;
	lcc_pkg::lcc_mode_t       contrast_mode;
	lcc_pkg::lcc_rail_t       rail_sel;
	logic                     reduced_drive_sel;
	logic                     mode_invalid;
	logic [15:0]              frame_count;
	logic [7:0]               lit_count;
	int                       miscompares;
	int                       comparisons;
	logic [7:0]               rv;
	logic [15:0]              f0;

	lcc_top DUT
	(
		.clock(clock), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .rtc_tick(rtc_tick),
		.refresh_tick(refresh_tick), .segment_pattern_regs(segment_pattern_regs),
		.seg_drive(seg_drive), .seg_pins_wide(seg_pins_wide),
		.backplane_mode(backplane_mode), .half_bias(half_bias), .battery_low(battery_low),
		.contrast_code(contrast_code), .setpoint_mv(setpoint_mv),
		.contrast_mode(contrast_mode), .rail_sel(rail_sel),
		.reduced_drive_sel(reduced_drive_sel), .mode_invalid(mode_invalid)
	);

	lcc_panel panel
	(
		.clock(clock), .nrst(nrst), .refresh_tick(refresh_tick), .seg_drive(seg_drive),
		.frame_count(frame_count), .lit_count(lit_count)
	);

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clock);
		#1 sfr_wr = 1'b0;
	endtask

	// Read data is taken one edge after the strobe is accepted
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		#1 sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clock);
		#1 sfr_rd = 1'b0;
		wt(1);
		d = sfr_rdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		rd(a, rv);
		check(16'(rv), 16'(e));
	endtask

	// Four mode bits and battery state against the expected mode and rail
	task automatic mode_case(input logic m, input logic c, input logic p, input logic v,
		input logic low, input logic [2:0] em, input logic [2:0] er);
		wr(lcc_pkg::ADDR_MASTER_CTL, {5'h00, m, 2'h0});
		wr(lcc_pkg::ADDR_MASTER_CFG, {7'h00, c});
		wr(lcc_pkg::ADDR_POWER_CTL, {4'h0, p, 3'h0});
		wr(lcc_pkg::ADDR_SUPPLY_MON, {v, 7'h00});
		battery_low = low;
		wt(6);
		check(16'(contrast_mode), 16'(em));
		check(16'(rail_sel), 16'(er));
		check(16'(reduced_drive_sel), 16'(m));
		check(16'(mode_invalid), 16'h0000);
		rd(lcc_pkg::ADDR_STATUS, rv);
		check(16'(rv[6:0]), 16'({low, er, em}));
	endtask

	task automatic wrap_up;
		$display("comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		miscompares = 0;
		comparisons = 0;
		nrst = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		rtc_tick = 1'b0;
		battery_low = 1'b0;
		segment_pattern_regs = {128{1'b1}};
		wt(5);
		nrst = 1'b1;
		wt(2);
		rd_chk(lcc_pkg::ADDR_SEG_CTL, 8'h00);
		rd_chk(lcc_pkg::ADDR_CONTRAST, 8'h00);
		rd_chk(lcc_pkg::ADDR_MASTER_CTL, 8'h20);
		rd_chk(8'h00, 8'h00);
		check(16'(mode_invalid), 16'h0001);
		check(16'(contrast_mode), 16'(lcc_pkg::MODE_NONE));
		$display("test reset done");
		wr(lcc_pkg::ADDR_SEG_CTL, 8'hFF);
		rd_chk(lcc_pkg::ADDR_SEG_CTL, 8'h7F);
		wr(lcc_pkg::ADDR_CONTRAST, 8'hFF);
		rd_chk(lcc_pkg::ADDR_CONTRAST, 8'h1F);
		check(16'(contrast_code), 16'h001F);
		check(16'(setpoint_mv), 16'(1900 + 60 * 31));
		wr(lcc_pkg::ADDR_CONTRAST, 8'h05);
		wt(2);
		check(16'(setpoint_mv), 16'(1900 + 60 * 5));
		$display("test contrast done");
		for (int k = 0; k < 4; k++)
		begin
			wr(lcc_pkg::ADDR_SEG_CTL, {4'h0, 1'b1, 2'(k), 1'b1});
			wt(2);
			check(16'(backplane_mode), 16'(k));
			check(16'(half_bias), 16'(k != 0));
			check(16'(lit_count), 16'(32 * (k + 1)));
			check(16'(seg_pins_wide), 16'h0001);
		end
		// Alternate commons lit, so gating must follow the pattern bits
		segment_pattern_regs = {32{4'h5}};
		wr(lcc_pkg::ADDR_SEG_CTL, 8'h0E);
		wt(2);
		check(16'(half_bias), 16'h0000);
		check(16'(lit_count), 16'h0040);
		wr(lcc_pkg::ADDR_SEG_CTL, 8'h1F);
		wt(2);
		check(16'(lit_count), 16'h0000);
		wr(lcc_pkg::ADDR_SEG_CTL, 8'h07);
		wt(2);
		check(16'(seg_pins_wide), 16'h0000);
		check(16'(lit_count), 16'h0020);
		$display("test segment control done");
		for (int d = 0; d < 3; d++)
		begin
			wr(lcc_pkg::ADDR_SEG_CTL, {1'b0, 2'(d), 5'h0E});
			wt(2);
			f0 = frame_count;
			repeat (8)
			begin
				rtc_tick = 1'b1;
				wt(1);
				rtc_tick = 1'b0;
				wt(1);
			end
			wt(2);
			check(frame_count - f0, 16'(8 >> d));
		end
		$display("test prescale done");
		mode_case(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, lcc_pkg::MODE_BYPASS, 3'b100);
		mode_case(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, lcc_pkg::MODE_BYPASS, 3'b100);
		mode_case(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, lcc_pkg::MODE_MINIMUM, 3'b100);
		mode_case(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, lcc_pkg::MODE_MINIMUM, 3'b001);
		mode_case(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, lcc_pkg::MODE_CONSTANT, 3'b010);
		mode_case(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, lcc_pkg::MODE_CONSTANT, 3'b001);
		mode_case(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, lcc_pkg::MODE_CONSTANT, 3'b010);
		mode_case(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, lcc_pkg::MODE_AUTO, 3'b010);
		mode_case(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, lcc_pkg::MODE_AUTO, 3'b100);
		mode_case(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, lcc_pkg::MODE_AUTO, 3'b100);
		// Monitor enable cleared from auto-bypass leaves no legal pattern
		wr(lcc_pkg::ADDR_SUPPLY_MON, 8'h00);
		wt(6);
		check(16'(mode_invalid), 16'h0001);
		check(16'(contrast_mode), 16'(lcc_pkg::MODE_NONE));
		check(16'(rail_sel), 16'h0000);
		$display("test contrast modes done");
		nrst = 1'b0;
		wt(2);
		nrst = 1'b1;
		wt(2);
		rd_chk(lcc_pkg::ADDR_CONTRAST, 8'h00);
		check(16'(setpoint_mv), 16'(1900));
		check(16'(mode_invalid), 16'h0001);
		$display("test mid-run reset done");
		wrap_up();
	end
endmodule
